// *** core/e1rcs_defs.vh ***
`ifndef E1RCS_DEFS_VH
`define E1RCS_DEFS_VH
// register offsets, framer page
`define E1RCS_SCF0_OFS 8'h0d
`define E1RCS_SCF1_OFS 8'h0e
`define E1RCS_SCF2_OFS 8'h0f
`define E1RCS_SCF3_OFS 8'h10
`define E1RCS_RX_INTERFACE_CONTROL_OFS 8'h20
`define E1RCS_RX_SIGNALING_CONTROL_OFS 8'ha0
// store array page spans these offsets
`define E1RCS_ARR_FIRST 8'h00
`define E1RCS_ARR_LAST 8'h1f
// field positions
`define E1RCS_RX_INTERFACE_CONTROL_FRAC_BIT 4
`define E1RCS_RX_SIGNALING_CONTROL_OHEN_BIT 5
`define E1RCS_RX_SIGNALING_CONTROL_MODE_HI 1
`define E1RCS_RX_SIGNALING_CONTROL_MODE_LO 0
// extraction modes
`define E1RCS_MODE_OFF 2'h0
`define E1RCS_MODE_SIXTEEN 2'h1
`define E1RCS_MODE_FOUR 2'h2
`define E1RCS_MODE_TWO 2'h3
// reset values
`define E1RCS_RX_INTERFACE_CONTROL_RST 8'h00
`define E1RCS_RX_SIGNALING_CONTROL_RST 8'h00
// stream positions
`define E1RCS_SIG_TS 5'h10
`define E1RCS_LAST_TS 5'h1f
`define E1RCS_LAST_FRM 4'hf
`define E1RCS_LAST_BIT 3'h7
`define E1RCS_NIB_BIT 3'h3
`endif

// *** core/e1rcs_sig_mem.v ***
`timescale 1ns/1ns
// two write ports (port a wins on a clash), two registered read ports
module e1rcs_sig_mem #(
  parameter DW = 8,
  parameter AW = 5
) (
  input wire clk_i, // clock
  input wire wa_en_i, // write a strobe
  input wire [AW-1:0] wa_addr_i, // write a address
  input wire [DW-1:0] wa_data_i, // write a data
  input wire wb_en_i, // write b strobe
  input wire [AW-1:0] wb_addr_i, // write b address
  input wire [DW-1:0] wb_data_i, // write b data
  input wire [AW-1:0] ra_addr_i, // read a address
  output reg [DW-1:0] ra_data_o, // read a data, next cycle
  input wire [AW-1:0] rb_addr_i, // read b address
  output reg [DW-1:0] rb_data_o // read b data, next cycle
);
  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  // storage writes
  always @(posedge clk_i) begin
    if (wa_en_i) begin
      mem_q[wa_addr_i] <= wa_data_i;
    end
    if (wb_en_i && !(wa_en_i && wa_addr_i == wb_addr_i)) begin
      mem_q[wb_addr_i] <= wb_data_i;
    end
  end

  // registered reads
  always @(posedge clk_i) begin
    ra_data_o <= mem_q[ra_addr_i];
    rb_data_o <= mem_q[rb_addr_i];
  end
endmodule // e1rcs_sig_mem

// *** core/e1rcs_buf2.v ***
`timescale 1ns/1ns
// two-entry buffer, valid/ready on both sides
module e1rcs_buf2 #(
  parameter W = 3
) (
  input wire clk_i, // clock
  input wire rst_i, // async reset, high
  input wire in_valid_i, // word offered
  output wire in_ready_o, // room for a word
  input wire [W-1:0] in_data_i, // word in
  output wire out_valid_o, // word available
  input wire out_ready_i, // sink takes word
  output wire [W-1:0] out_data_o // word out
);
  reg [W-1:0] e0_q;
  reg [W-1:0] e1_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready_o = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = e0_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // e0 is the head, e1 the second slot
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      e0_q <= {W{1'b0}};
      e1_q <= {W{1'b0}};
      cnt_q <= 2'h0;
    end else begin
      if (pop) begin
        e0_q <= (cnt_q == 2'h2) ? e1_q : in_data_i;
      end else if (push && cnt_q == 2'h0) begin
        e0_q <= in_data_i;
      end
      if (push && ((cnt_q == 2'h1 && !pop) || (cnt_q == 2'h2))) begin
        e1_q <= in_data_i;
      end
      if (push && !(pop && cnt_q != 2'h1)) begin
        cnt_q <= pop ? cnt_q : cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule // e1rcs_buf2

// *** core/e1rcs_top.v ***
`timescale 1ns/1ns
`include "e1rcs_defs.vh"
// Functional notes
// - four 8-bit change-flag registers; msb is lowest timeslot of its group
// - updated flag plus four change-flag registers name every changed timeslot
// - signaling goes to array, signaling pin, overhead pin and serial stream
// - extraction enabled: timeslot 16 signaling written into its timeslot entry
// - sixteen-code array entry holds A in bit 3, B bit 2, C bit 1, D bit 0
// - 32 array entries at 0x00 to 0x1f, readable by the processor
// - interface control bit 4: 0 timeslot bit 0 on pin, 1 signaling
// - signaling pin A..D aligned with serial data bits 3..0
// - overhead pin selected: all timeslot 16 data shown on it
// - channels 1-15 A..D sit in timeslot 16 bits 1..4
// - channels 17-31 A..D sit in timeslot 16 bits 5..8
// - signaling control bit 5 gates the overhead pin path
// - change flag one means that timeslot changed last multiframe
// - mode field: 00 off, 01 sixteen, 10 four, 11 two-code
// - new signaling compared with old; change sets updated flag at multiframe end
// - signaling always stays embedded in the serial output payload
module e1rcs_top (
  input wire clk_i, // 20 MHz clock
  input wire rst_i, // async reset, high
  input wire rx_bit_valid_i, // framer offers a received bit
  output wire rx_bit_ready_o, // block takes the bit
  input wire rx_bit_i, // received pcm bit
  input wire [4:0] rx_ts_i, // timeslot of the bit
  input wire [2:0] rx_bitn_i, // bit index, 0 is pcm bit 1 (msb)
  input wire [3:0] rx_frm_i, // frame number in multiframe
  input wire reg_arr_sel_i, // 1 selects the store array page
  input wire [7:0] reg_addr_i, // indirect register offset
  input wire reg_wr_i, // register write strobe
  input wire reg_rd_i, // register read strobe
  input wire [7:0] reg_wdata_i, // write data
  output reg [7:0] reg_rdata_o, // read data
  output reg reg_rvalid_o, // read data valid pulse
  output reg signaling_update_event_o, // updated status flag (sticky)
  input wire signaling_update_clr_i, // clears the updated flag
  output wire out_valid_o, // output bit valid
  input wire out_ready_i, // terminal takes output bit
  output wire rx_serial_out_pin_o, // serial payload bit
  output wire rx_signaling_out_pin_o, // signaling or timeslot bit 0 pin
  output wire rx_overhead_out_pin_o // overhead pin
);
  // control registers
  reg [7:0] rx_interface_control_q;
  reg [7:0] rx_signaling_control_q;
  // change tracking
  reg [31:0] pend_q;
  reg [31:0] flags_q;
  // input stage
  reg s_v_q;
  reg s_age_q;
  reg s_bit_q;
  reg [4:0] s_ts_q;
  reg [2:0] s_bitn_q;
  reg [3:0] s_frm_q;
  reg [2:0] nib_q;
  // processor read pipe
  reg rd_arr_q;
  reg rd_q;
  reg [7:0] rd_reg_q;

  wire [1:0] mode;
  wire frac_en;
  wire oh_en;
  wire [7:0] ext_rdata;
  wire [7:0] cpu_rdata;
  wire buf_in_ready;
  wire act;
  wire in_sig_ts;
  wire nib_end;
  wire ext_wr;
  wire [4:0] chan;
  wire [4:0] rd_addr;
  wire [3:0] raw_nib;
  wire [3:0] new_sig;
  wire changed;
  wire mf_end;
  wire [31:0] pend_next;
  wire sig_bit;
  wire mux_bit;
  wire oh_bit;
  wire cpu_arr_wr;

  // bit order of one change-flag byte: msb is the lowest timeslot
  // byte g covers timeslots 8g to 8g+7
  function [7:0] flag_byte;
    input [31:0] f;
    input [1:0] grp;
    integer k;
    begin
      flag_byte = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        flag_byte[7-k] = f[{grp, 3'h0} + k];
      end
    end
  endfunction

  // condense a received nibble according to the code width
  // four-code keeps A,B twice over; two-code keeps A in all four bits
  function [3:0] code_map;
    input [1:0] m;
    input [3:0] n;
    begin
      case (m)
        `E1RCS_MODE_SIXTEEN: code_map = n;
        `E1RCS_MODE_FOUR: code_map = {n[3], n[2], n[3], n[2]};
        `E1RCS_MODE_TWO: code_map = {n[3], n[3], n[3], n[3]};
        default: code_map = 4'h0;
      endcase
    end
  endfunction

  // store array page hit: page selected and offset inside the array span
  function arr_hit;
    input sel;
    input [7:0] a;
    begin
      arr_hit = sel && (a <= `E1RCS_ARR_LAST);
    end
  endfunction

  assign mode = rx_signaling_control_q[`E1RCS_RX_SIGNALING_CONTROL_MODE_HI:`E1RCS_RX_SIGNALING_CONTROL_MODE_LO];
  assign frac_en = rx_interface_control_q[`E1RCS_RX_INTERFACE_CONTROL_FRAC_BIT];
  assign oh_en = rx_signaling_control_q[`E1RCS_RX_SIGNALING_CONTROL_OHEN_BIT];

  // one bit held in the stage; memory answers one cycle after it lands
  assign rx_bit_ready_o = !s_v_q;
  assign act = s_v_q && s_age_q && buf_in_ready;
  assign in_sig_ts = (s_ts_q == `E1RCS_SIG_TS);
  assign nib_end = (s_bitn_q == `E1RCS_NIB_BIT) || (s_bitn_q == `E1RCS_LAST_BIT);
  // first nibble is channel n, second channel n+16
  assign chan = (s_bitn_q[2] == 1'b0) ? {1'b0, s_frm_q} : {1'b1, s_frm_q};
  // in timeslot 16 look up the channel, elsewhere the timeslot itself
  assign rd_addr = in_sig_ts ? chan : s_ts_q;

  // frame 0 carries the alignment word, never signaling
  assign raw_nib = {nib_q, s_bit_q};
  assign new_sig = code_map(mode, raw_nib);
  assign ext_wr = act && in_sig_ts && nib_end && (s_frm_q != 4'h0)
    && (mode != `E1RCS_MODE_OFF);
  assign changed = ext_wr && (new_sig != ext_rdata[3:0]);
  // multiframe ends when its very last bit leaves the stage
  assign mf_end = act && (s_frm_q == `E1RCS_LAST_FRM) && (s_ts_q == `E1RCS_LAST_TS)
    && (s_bitn_q == `E1RCS_LAST_BIT);
  assign pend_next = pend_q | (changed ? (32'h1 << chan) : 32'h0);
  assign cpu_arr_wr = reg_wr_i && arr_hit(reg_arr_sel_i, reg_addr_i);

  // signaling pin: A..D over data bits 3..0 of each timeslot except timeslot 16, which gives 0
  assign sig_bit = (!in_sig_ts && s_bitn_q[2]) ? ext_rdata[~s_bitn_q[1:0]] : 1'b0;
  assign mux_bit = frac_en ? sig_bit : s_ts_q[0];
  // overhead pin copies timeslot 16 raw when enabled
  assign oh_bit = oh_en && in_sig_ts && s_bit_q;

  // extraction reads the old entry a cycle before it writes, so a change is seen
  // signaling array, port a extraction, port b processor
  e1rcs_sig_mem #(
    .DW(8),
    .AW(5)
  ) u_mem (
    .clk_i(clk_i),
    .wa_en_i(ext_wr),
    .wa_addr_i(chan),
    .wa_data_i({4'h0, new_sig}),
    .wb_en_i(cpu_arr_wr),
    .wb_addr_i(reg_addr_i[4:0]),
    .wb_data_i(reg_wdata_i),
    .ra_addr_i(rd_addr),
    .ra_data_o(ext_rdata),
    .rb_addr_i(reg_addr_i[4:0]),
    .rb_data_o(cpu_rdata)
  );

  // a full buffer holds the stage, so a stalled sink never loses a bit
  // output buffer: serial payload always carries signaling
  e1rcs_buf2 #(
    .W(3)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(s_v_q && s_age_q),
    .in_ready_o(buf_in_ready),
    .in_data_i({s_bit_q, mux_bit, oh_bit}),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o({rx_serial_out_pin_o, rx_signaling_out_pin_o, rx_overhead_out_pin_o})
  );

  // the framer stalls on ready while a bit waits for its memory look-up
  // input stage capture and release
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_v_q <= 1'b0;
      s_age_q <= 1'b0;
      s_bit_q <= 1'b0;
      s_ts_q <= 5'h00;
      s_bitn_q <= 3'h0;
      s_frm_q <= 4'h0;
    end else begin
      if (!s_v_q && rx_bit_valid_i) begin
        s_v_q <= 1'b1;
        s_age_q <= 1'b0;
        s_bit_q <= rx_bit_i;
        s_ts_q <= rx_ts_i;
        s_bitn_q <= rx_bitn_i;
        s_frm_q <= rx_frm_i;
      end else if (act) begin
        s_v_q <= 1'b0;
        s_age_q <= 1'b0;
      end else if (s_v_q) begin
        s_age_q <= 1'b1;
      end
    end
  end

  // nib_q keeps the three signaling bits before the one in the stage
  // timeslot 16 nibble collector
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nib_q <= 3'h0;
    end else if (act && in_sig_ts) begin
      nib_q <= {nib_q[1:0], s_bit_q};
    end
  end

  // a change in the last cycle of the multiframe still lands in this snapshot
  // change tracking and multiframe snapshot
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q <= 32'h0;
      flags_q <= 32'h0;
    end else if (mf_end) begin
      flags_q <= pend_next;
      pend_q <= 32'h0;
    end else begin
      pend_q <= pend_next;
    end
  end

  // the clear comes from the caller, who picks read- or write-clear
  // updated flag: a set in the clearing cycle wins
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      signaling_update_event_o <= 1'b0;
    end else if (mf_end && (pend_next != 32'h0)) begin
      signaling_update_event_o <= 1'b1;
    end else if (signaling_update_clr_i) begin
      signaling_update_event_o <= 1'b0;
    end
  end

  // change-flag offsets are read-only; writes there fall through
  // control register writes
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_interface_control_q <= `E1RCS_RX_INTERFACE_CONTROL_RST;
      rx_signaling_control_q <= `E1RCS_RX_SIGNALING_CONTROL_RST;
    end else if (reg_wr_i && !reg_arr_sel_i) begin
      if (reg_addr_i == `E1RCS_RX_INTERFACE_CONTROL_OFS) begin
        rx_interface_control_q <= reg_wdata_i;
      end
      if (reg_addr_i == `E1RCS_RX_SIGNALING_CONTROL_OFS) begin
        rx_signaling_control_q <= reg_wdata_i;
      end
    end
  end

  // framer page read decode, registered
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_q <= 1'b0;
      rd_arr_q <= 1'b0;
      rd_reg_q <= 8'h00;
    end else begin
      rd_q <= reg_rd_i;
      rd_arr_q <= arr_hit(reg_arr_sel_i, reg_addr_i);
      // the array page owns no control offsets; its spare offsets read zero
      if (reg_arr_sel_i) begin
        rd_reg_q <= 8'h00;
      end else begin
        case (reg_addr_i)
          `E1RCS_SCF0_OFS: rd_reg_q <= flag_byte(flags_q, 2'h0);
          `E1RCS_SCF1_OFS: rd_reg_q <= flag_byte(flags_q, 2'h1);
          `E1RCS_SCF2_OFS: rd_reg_q <= flag_byte(flags_q, 2'h2);
          `E1RCS_SCF3_OFS: rd_reg_q <= flag_byte(flags_q, 2'h3);
          `E1RCS_RX_INTERFACE_CONTROL_OFS: rd_reg_q <= rx_interface_control_q;
          `E1RCS_RX_SIGNALING_CONTROL_OFS: rd_reg_q <= rx_signaling_control_q;
          default: rd_reg_q <= 8'h00;
        endcase
      end
    end
  end

  // data are forced to zero outside the answer, so a stray sample sees nothing
  // read answer one cycle after the strobe
  always @* begin
    reg_rvalid_o = rd_q;
    if (!rd_q) begin
      reg_rdata_o = 8'h00;
    end else if (rd_arr_q) begin
      reg_rdata_o = cpu_rdata;
    end else begin
      reg_rdata_o = rd_reg_q;
    end
  end
endmodule // e1rcs_top

// *** bench/e1rcs_top_assertions.sv ***
`timescale 1ns/1ns
// port checks of the signaling route block
module e1rcs_chk (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire rx_bit_valid_i, // bit offered
  input wire rx_bit_ready_o, // bit taken
  input wire [4:0] rx_ts_i, // timeslot
  input wire [2:0] rx_bitn_i, // bit index
  input wire [3:0] rx_frm_i, // frame
  input wire reg_arr_sel_i, // page
  input wire [7:0] reg_addr_i, // offset
  input wire reg_rd_i, // read
  input wire [7:0] reg_rdata_o, // data
  input wire reg_rvalid_o, // valid
  input wire signaling_update_event_o, // updated
  input wire signaling_update_clr_i, // clear
  input wire out_valid_o, // word
  input wire out_ready_i, // sink
  input wire rx_serial_out_pin_o, // serial
  input wire rx_signaling_out_pin_o, // sig
  input wire rx_overhead_out_pin_o // oh
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // last bit of a multiframe handed over
  wire last_w = rx_bit_valid_i && rx_bit_ready_o && rx_frm_i == 4'hf && rx_ts_i == 5'h1f
    && rx_bitn_i == 3'h7;
  // cycles since the last bit of a multiframe was taken, saturating
  logic [7:0] since_q;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) since_q <= 8'hff;
    else if (last_w) since_q <= 8'h00;
    else if (since_q != 8'hff) since_q <= since_q + 8'h01;
  end
  sequence s_take;
    rx_bit_valid_i && rx_bit_ready_o;
  endsequence
  sequence s_busy;
    !rx_bit_ready_o [*2];
  endsequence
  property p_rvalid;
    1 |=> reg_rvalid_o == $past(reg_rd_i);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");
  property p_rzero;
    !reg_rvalid_o |-> reg_rdata_o == 8'h00;
  endproperty
  a_rzero: assert property (p_rzero) else $error("read data outside answer");
  property p_unmap;
    reg_rd_i && (reg_arr_sel_i ? reg_addr_i > 8'h1f : !(reg_addr_i inside
      {8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h20, 8'ha0})) |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped offset not zero");
  property p_hold;
    s_take |=> s_busy;
  endproperty
  a_hold: assert property (p_hold) else $error("input stage took too soon");
  property p_out;
    s_take |-> ##[1:60] out_valid_o;
  endproperty
  a_out: assert property (p_out) else $error("taken bit never output");
  property p_stand;
    out_valid_o && !out_ready_i |=> out_valid_o && $stable({rx_serial_out_pin_o,
      rx_signaling_out_pin_o, rx_overhead_out_pin_o});
  endproperty
  a_stand: assert property (p_stand) else $error("stalled word changed");
  property p_sticky;
    signaling_update_event_o && !signaling_update_clr_i |=> signaling_update_event_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("updated flag lost");
  property p_rise;
    $rose(signaling_update_event_o) |-> since_q >= 8'h02 && since_q <= 8'h28;
  endproperty
  a_rise: assert property (p_rise) else $error("updated flag off boundary");
  property p_clr;
    signaling_update_clr_i && since_q > 8'h28 |=> !signaling_update_event_o;
  endproperty
  a_clr: assert property (p_clr) else $error("updated flag not cleared");
endmodule // e1rcs_chk
bind e1rcs_top e1rcs_chk e1rcs_chk_inst (.clk_i, .rst_i, .rx_bit_valid_i, .rx_bit_ready_o,
  .rx_ts_i, .rx_bitn_i, .rx_frm_i, .reg_arr_sel_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
  .reg_rvalid_o, .signaling_update_event_o, .signaling_update_clr_i, .out_valid_o,
  .out_ready_i, .rx_serial_out_pin_o, .rx_signaling_out_pin_o, .rx_overhead_out_pin_o);

// *** bench/e1rcs_term_model.sv ***
`timescale 1ns/1ns
// terminal equipment sink, prompt or taking one word in four
module e1rcs_term_model (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire valid_i, // word offered
  input wire slow_i, // slow pace
  output logic ready_o, // takes word
  output logic [15:0] taken_o // words taken
);
  logic [1:0] ph_q;
  // ready pattern and count of words taken
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_q <= 2'h0;
      ready_o <= 1'b0;
      taken_o <= 16'h0000;
    end else begin
      ph_q <= ph_q + 2'h1;
      ready_o <= !slow_i || ph_q == 2'h3;
      if (valid_i && ready_o)
        taken_o <= taken_o + 16'h0001;
    end
  end
endmodule // e1rcs_term_model

// *** bench/e1rcs_top_tb.sv ***
`timescale 1ns/1ns
module e1rcs_top_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, rx_bit_valid_i = 1'b0, rx_bit_i = 1'b0, slow = 1'b0;
  logic reg_arr_sel_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, signaling_update_clr_i = 1'b0;
  logic [4:0] rx_ts_i = 5'h00;
  logic [2:0] rx_bitn_i = 3'h0;
  logic [3:0] rx_frm_i = 4'h0, sh = 4'h0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rc = 8'h00, sc = 8'h00;
  logic [3:0] ea [32];
  logic [3:0] nx [32];
  logic [31:0] pend = 0, fexp = 0;
  logic uexp = 1'b0;
  logic [2:0] eq [$];
  int num_errors = 0, checks_done = 0;
  wire rx_bit_ready_o, reg_rvalid_o, signaling_update_event_o, out_valid_o, out_ready_i;
  wire rx_serial_out_pin_o, rx_signaling_out_pin_o, rx_overhead_out_pin_o;
  wire [7:0] reg_rdata_o;
  wire [15:0] taken;
  e1rcs_top e1rcs_top_inst (.clk_i, .rst_i, .rx_bit_valid_i, .rx_bit_ready_o, .rx_bit_i,
    .rx_ts_i, .rx_bitn_i, .rx_frm_i, .reg_arr_sel_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .signaling_update_event_o,
    .signaling_update_clr_i, .out_valid_o, .out_ready_i, .rx_serial_out_pin_o,
    .rx_signaling_out_pin_o, .rx_overhead_out_pin_o);
  e1rcs_term_model e1rcs_term_model_inst (.clk_i, .rst_i, .valid_i(out_valid_o),
    .slow_i(slow), .ready_o(out_ready_i), .taken_o(taken));
  always #25 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // each popped word against its expected pins
  always @(posedge clk_i) begin
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1 && eq.size() > 0)
      chk({rx_serial_out_pin_o, rx_signaling_out_pin_o, rx_overhead_out_pin_o},
        eq.pop_front());
  end
  task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_arr_sel_i <= s;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    if (!s && a == 8'h20) rc = d;
    if (!s && a == 8'ha0) sc = d;
  endtask
  task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_arr_sel_i <= s;
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rvalid_o, 1'b1);
    chk(reg_rdata_o, e);
  endtask
  // offer one bit, model its pins and extraction, wait until taken
  task automatic sb(input logic b, input logic [4:0] t, input logic [2:0] n, input logic [3:0] f);
    logic r;
    logic [3:0] nv;
    logic [4:0] c;
    int k;
    rx_bit_valid_i <= 1'b1;
    rx_bit_i <= b;
    rx_ts_i <= t;
    rx_bitn_i <= n;
    rx_frm_i <= f;
    eq.push_back({b, rc[4] ? (t != 5'h10 && n[2] && ea[t][3'h7 - n]) : t[0],
      b && t == 5'h10 && sc[5]});
    sh = {sh[2:0], b};
    nv = sc[1:0] == 2'h1 ? sh : sc[1:0] == 2'h2 ? {sh[3:2], sh[3:2]} : {4{sh[3]}};
    c = {n[2], f};
    if (t == 5'h10 && f != 4'h0 && sc[1:0] != 2'h0 && n[1:0] == 2'h3) begin
      if (nv != ea[c]) pend[c] = 1'b1;
      ea[c] = nv;
    end
    if (f == 4'hf && t == 5'h1f && n == 3'h7) begin
      fexp = pend;
      uexp = uexp | (pend != 0);
      pend = 0;
    end
    k = 0;
    do begin
      @(negedge clk_i);
      r = rx_bit_ready_o;
      @(posedge clk_i);
      k++;
    end while (r !== 1'b1 && k < 200);
    if (r !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic run_mf();
    logic [7:0] by;
    logic [15:0] t0;
    int k;
    @(posedge clk_i);
    t0 = taken;
    for (int f = 0; f < 16; f++) for (int t = 0; t < 32; t++) begin
      by = (t == 16 && f != 0) ? {nx[f], nx[f+16]} : ({f[3:0], t[3:0]} ^ 8'h5a);
      for (int n = 0; n < 8; n++) sb(by[7-n], t[4:0], n[2:0], f[3:0]);
    end
    rx_bit_valid_i <= 1'b0;
    k = 0;
    while (eq.size() != 0 && k < 500) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if (eq.size() != 0) begin
      num_errors++;
      end_of_test();
    end
    chk(taken - t0, 16'h1000);
  endtask
  task automatic rflags();
    logic [7:0] e;
    for (int g = 0; g < 4; g++) begin
      for (int j = 0; j < 8; j++) e[7-j] = fexp[8*g+j];
      rd(1'b0, 8'h0d + g[7:0], e);
    end
    chk(signaling_update_event_o, uexp);
  endtask
  task automatic t_regs();
    rd(1'b0, 8'h20, 8'h00);
    rd(1'b0, 8'ha0, 8'h00);
    wr(1'b0, 8'h0d, 8'hff);
    rd(1'b0, 8'h0d, 8'h00);
    rd(1'b0, 8'h55, 8'h00);
    for (int c = 31; c >= 0; c--) wr(1'b1, c[7:0], c == 0 ? 8'ha5 : 8'h00);
    for (int c = 0; c < 32; c++) ea[c] = c == 0 ? 4'h5 : 4'h0;
    rd(1'b1, 8'h00, 8'ha5);
    rd(1'b1, 8'h1f, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_sixteen();
    for (int c = 0; c < 32; c++) nx[c] = c[3:0] ^ 4'h9;
    wr(1'b0, 8'ha0, 8'h21);
    wr(1'b0, 8'h20, 8'h10);
    run_mf();
    rflags();
    for (int c = 0; c < 32; c++) rd(1'b1, c[7:0], c == 0 ? 8'ha5 : {4'h0, ea[c]});
    @(posedge clk_i);
    signaling_update_clr_i <= 1'b1;
    @(posedge clk_i);
    signaling_update_clr_i <= 1'b0;
    uexp = 1'b0;
    #1;
    chk(signaling_update_event_o, 1'b0);
    nx[5] = nx[5] ^ 4'h1;
    nx[20] = nx[20] ^ 4'h8;
    slow = 1'b1;
    run_mf();
    slow <= 1'b0;
    rflags();
    $display("t_sixteen done");
  endtask
  task automatic t_modes();
    for (int m = 2; m < 5; m++) begin
      wr(1'b0, 8'ha0, {2'h0, m[0], 3'h0, m[1:0]});
      wr(1'b0, 8'h20, {3'h0, m[1], 4'h0});
      run_mf();
      rflags();
    end
    $display("t_modes done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_sixteen();
    t_modes();
    end_of_test();
  end
endmodule // e1rcs_top_tb
